// ---- ddr_timing_pkg.sv ----
package ddr_timing_pkg;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_RD,
      CMD_WR,
      CMD_PRE,
      CMD_REF,
      CMD_MODE
   } cmd_t;

   // Pin patterns {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] PINS_NOP  = 4'h7;
   localparam logic [3:0] PINS_ACT  = 4'h3;
   localparam logic [3:0] PINS_RD   = 4'h5;
   localparam logic [3:0] PINS_WR   = 4'h4;
   localparam logic [3:0] PINS_PRE  = 4'h2;
   localparam logic [3:0] PINS_REF  = 4'h1;
   localparam logic [3:0] PINS_MODE = 4'h0;

   localparam int BANKS               = 4;
   localparam int BANK_W              = 2;
   localparam int ADDR_W              = 13;
   localparam int PRECHARGE_SCOPE_POS = 10;

   // Times in picoseconds, fast grade and slower grades
   localparam int CK_MAX_PS                     = 12000;
   localparam int ACTIVATE_TO_CLOSE_MIN_FAST_PS = 42000;
   localparam int ACTIVATE_TO_CLOSE_MIN_SLOW_PS = 45000;
   localparam int ACTIVATE_TO_CLOSE_MAX_PS      = 120000000;
   localparam int SAME_BANK_ACTIVATE_FAST_PS    = 60000;
   localparam int SAME_BANK_ACTIVATE_SLOW_PS    = 65000;
   localparam int REFRESH_CYCLE_FAST_PS         = 72000;
   localparam int REFRESH_CYCLE_SLOW_PS         = 75000;
   localparam int ACTIVATE_TO_ACCESS_FAST_PS    = 18000;
   localparam int ACTIVATE_TO_ACCESS_SLOW_PS    = 20000;
   localparam int CLOSE_TO_ACTIVATE_FAST_PS     = 18000;
   localparam int CLOSE_TO_ACTIVATE_SLOW_PS     = 20000;
   localparam int CROSS_BANK_GAP_FAST_PS        = 12000;
   localparam int CROSS_BANK_GAP_SLOW_PS        = 15000;
   localparam int WRITE_RECOVERY_PS             = 15000;
   localparam int REFRESH_INTERVAL_AVG_PS       = 7800000;
   localparam int WRITE_PREAMBLE_SETUP_PS       = 0;

   // Counts in link clock cycles
   localparam int MODE_PROGRAM_CYCLE        = 2;
   localparam int WRITE_TO_READ_GAP         = 1;
   localparam int WRITE_CMD_TO_FIRST_STROBE = 1;
   localparam int MODULE_REGISTER_DELAY     = 1;
   localparam int OPEN_GUARD_CYC            = 8;

   // Least time: round up, never below one cycle
   function automatic int ceil_cyc(input int ps, input int ck_ps);
      int c;
      c = (ps + ck_ps - 1) / ck_ps;
      return (c < 1) ? 1 : c;
   endfunction

   // Longest time: round down, never below one cycle
   function automatic int floor_cyc(input int ps, input int ck_ps);
      int c;
      c = ps / ck_ps;
      return (c < 1) ? 1 : c;
   endfunction

endpackage

// ---- spacing_timer.sv ----
module spacing_timer #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] cycles,
   output logic              busy
);

   logic [W-1:0] cnt_q;

   // Holds off for cycles-1 edges after the loading edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= (cycles == '0) ? '0 : cycles - W'(1);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign busy = (cnt_q != '0);

endmodule

// ---- ddr_cmd_scheduler.sv ----
module ddr_cmd_scheduler
   import ddr_timing_pkg::*;
#(
   parameter int CK_PERIOD_PS = 7500,
   parameter bit FAST_GRADE   = 1'b0,
   parameter int BURST_LEN    = 4,
   parameter int READ_LATENCY = 2,
   parameter int RAS_MAX_CYC  =
      ddr_timing_pkg::floor_cyc(ddr_timing_pkg::ACTIVATE_TO_CLOSE_MAX_PS,
                                CK_PERIOD_PS)
) (
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   input  wire logic                               mem_clk,
   input  wire logic                               req_valid,
   input  wire ddr_timing_pkg::cmd_t               req_cmd,
   input  wire logic [ddr_timing_pkg::BANK_W-1:0]  req_bank,
   input  wire logic [ddr_timing_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic                               req_scope,
   output logic                                    req_ready,
   output logic                                    cke,
   output logic                                    cs_n,
   output logic                                    ras_n,
   output logic                                    cas_n,
   output logic                                    we_n,
   output logic [ddr_timing_pkg::BANK_W-1:0]       ba,
   output logic [ddr_timing_pkg::ADDR_W-1:0]       addr,
   output logic                                    dqs_o,
   output logic                                    dqs_oe_n,
   output logic                                    capture_en
);
   import ddr_timing_pkg::*;

   localparam int TW  = 8;
   localparam int BL2 = BURST_LEN / 2;
   localparam int MOD_LAT = READ_LATENCY + MODULE_REGISTER_DELAY;
   localparam int RAS_CYC = ceil_cyc(FAST_GRADE ?
      ACTIVATE_TO_CLOSE_MIN_FAST_PS : ACTIVATE_TO_CLOSE_MIN_SLOW_PS,
      CK_PERIOD_PS);
   localparam int RC_CYC  = ceil_cyc(FAST_GRADE ?
      SAME_BANK_ACTIVATE_FAST_PS : SAME_BANK_ACTIVATE_SLOW_PS, CK_PERIOD_PS);
   localparam int RFC_CYC = ceil_cyc(FAST_GRADE ?
      REFRESH_CYCLE_FAST_PS : REFRESH_CYCLE_SLOW_PS, CK_PERIOD_PS);
   localparam int RCD_CYC = ceil_cyc(FAST_GRADE ?
      ACTIVATE_TO_ACCESS_FAST_PS : ACTIVATE_TO_ACCESS_SLOW_PS, CK_PERIOD_PS);
   localparam int RP_CYC  = ceil_cyc(FAST_GRADE ?
      CLOSE_TO_ACTIVATE_FAST_PS : CLOSE_TO_ACTIVATE_SLOW_PS, CK_PERIOD_PS);
   localparam int RRD_CYC = ceil_cyc(FAST_GRADE ?
      CROSS_BANK_GAP_FAST_PS : CROSS_BANK_GAP_SLOW_PS, CK_PERIOD_PS);
   localparam int WR_CYC  = ceil_cyc(WRITE_RECOVERY_PS, CK_PERIOD_PS);
   localparam int DAL_CYC = WR_CYC + RP_CYC;
   localparam int REFI_CYC = floor_cyc(REFRESH_INTERVAL_AVG_PS, CK_PERIOD_PS);
   localparam int WDATA_CYC = BL2 + WRITE_CMD_TO_FIRST_STROBE;
   localparam int SH_LEN = MOD_LAT + BL2 + 1;

   if (CK_PERIOD_PS > CK_MAX_PS || CK_PERIOD_PS < 1000) begin : g_chk_ck
      $error("Link clock period out of range");
   end
   if (BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8) begin : g_chk_bl
      $error("Burst length must be 2, 4 or 8");
   end
   if (READ_LATENCY < 1 || READ_LATENCY > 8) begin : g_chk_lat
      $error("Read latency out of range");
   end
   if (RAS_MAX_CYC <= OPEN_GUARD_CYC + RAS_CYC || RAS_MAX_CYC > 65535)
   begin : g_chk_ras
      $error("Open window count out of range");
   end
   if (RFC_CYC > 255 || DAL_CYC + WDATA_CYC > 255 || REFI_CYC > 4095)
   begin : g_chk_w
      $error("Timing count exceeds counter width");
   end

   // Request side, system clock domain
   cmd_t              hold_cmd_q;
   logic [BANK_W-1:0] hold_bank_q;
   logic [ADDR_W-1:0] hold_addr_q;
   logic              hold_scope_q;
   logic              req_tgl_q;
   logic              req_ready_q;
   logic              ack_s1_q;
   logic              ack_s2_q;
   logic              ack_s3_q;
   logic              ack_tgl_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cmd_q   <= CMD_NOP;
         hold_bank_q  <= '0;
         hold_addr_q  <= '0;
         hold_scope_q <= 1'b0;
         req_tgl_q    <= 1'b0;
         req_ready_q  <= 1'b1;
      end else if (req_valid && req_ready_q) begin
         hold_cmd_q   <= req_cmd;
         hold_bank_q  <= req_bank;
         hold_addr_q  <= req_addr;
         hold_scope_q <= req_scope;
         req_tgl_q    <= ~req_tgl_q;
         req_ready_q  <= 1'b0;
      end else if (ack_s2_q != ack_s3_q) begin
         req_ready_q  <= 1'b1;
      end
   end

   assign req_ready = req_ready_q;

   // Link side, link clock domain
   logic             rq_s1_q;
   logic             rq_s2_q;
   logic             rq_s3_q;
   logic             pend_q;
   logic             ref_pend_q;
   logic [11:0]      refi_q;
   logic [BANKS-1:0] open_q;
   logic [BANKS-1:0] due;
   logic [BANKS-1:0] rc_busy;
   logic [BANKS-1:0] ras_busy;
   logic [BANKS-1:0] rcd_busy;
   logic [BANKS-1:0] rp_busy;
   logic             mrd_busy;
   logic             rfc_busy;
   logic             rrd_busy;
   logic             wtr_busy;
   logic             wpd_busy;
   logic             bst_busy;
   cmd_t             iss_cmd;
   logic [BANK_W-1:0] iss_bank;
   logic             iss_a10;
   logic             take_user;
   logic             legal;
   logic [BANK_W-1:0] due_bank;
   logic             ras_ok_all;
   logic [SH_LEN-1:0] rd_sh_q;
   logic [SH_LEN-1:0] wr_sh_q;

   always_ff @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         rq_s1_q <= 1'b0;
         rq_s2_q <= 1'b0;
         rq_s3_q <= 1'b0;
      end else begin
         rq_s1_q <= req_tgl_q;
         rq_s2_q <= rq_s1_q;
         rq_s3_q <= rq_s2_q;
      end
   end

   // Held request stays stable until acknowledged back
   always_ff @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q    <= 1'b0;
         ack_tgl_q <= 1'b0;
      end else begin
         if (rq_s2_q != rq_s3_q) begin
            pend_q <= 1'b1;
         end else if (take_user) begin
            pend_q <= 1'b0;
         end
         if (take_user) begin
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // Free-running interval keeps the average exact; set wins over clear
   always_ff @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         refi_q     <= '0;
         ref_pend_q <= 1'b0;
      end else begin
         if (refi_q == 12'(REFI_CYC - 1)) begin
            refi_q     <= '0;
            ref_pend_q <= 1'b1;
         end else begin
            refi_q <= refi_q + 12'h001;
            if (iss_cmd == CMD_REF) begin
               ref_pend_q <= 1'b0;
            end
         end
      end
   end

   // Per-bank state and spacing trackers
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      logic        act_b;
      logic        close_b;
      logic        dal_b;
      logic [15:0] age_q;

      assign act_b   = (iss_cmd == CMD_ACT) && (iss_bank == BANK_W'(b));
      assign dal_b   = (iss_cmd == CMD_WR) && iss_a10 &&
                       (iss_bank == BANK_W'(b));
      assign close_b = ((iss_cmd == CMD_PRE) &&
                        (iss_a10 || iss_bank == BANK_W'(b))) ||
                       ((iss_cmd == CMD_RD || iss_cmd == CMD_WR) &&
                        iss_a10 && iss_bank == BANK_W'(b));

      always_ff @(posedge mem_clk or negedge rst_n) begin
         if (!rst_n) begin
            open_q[b] <= 1'b0;
         end else if (act_b) begin
            open_q[b] <= 1'b1;
         end else if (close_b) begin
            open_q[b] <= 1'b0;
         end
      end

      always_ff @(posedge mem_clk or negedge rst_n) begin
         if (!rst_n) begin
            age_q <= '0;
         end else if (act_b) begin
            age_q <= '0;
         end else if (open_q[b] && age_q != 16'hFFFF) begin
            age_q <= age_q + 16'h0001;
         end
      end

      assign due[b] = open_q[b] &&
                      (age_q >= 16'(RAS_MAX_CYC - OPEN_GUARD_CYC));

      spacing_timer #(.W(TW)) u_rc (
         .clk(mem_clk), .rst_n(rst_n), .load(act_b),
         .cycles(TW'(RC_CYC)), .busy(rc_busy[b]));
      spacing_timer #(.W(TW)) u_ras (
         .clk(mem_clk), .rst_n(rst_n), .load(act_b),
         .cycles(TW'(RAS_CYC)), .busy(ras_busy[b]));
      spacing_timer #(.W(TW)) u_rcd (
         .clk(mem_clk), .rst_n(rst_n), .load(act_b),
         .cycles(TW'(RCD_CYC)), .busy(rcd_busy[b]));
      spacing_timer #(.W(TW)) u_rp (
         .clk(mem_clk), .rst_n(rst_n), .load(close_b),
         .cycles(dal_b ? TW'(DAL_CYC + WDATA_CYC) :
                 (iss_cmd == CMD_RD) ? TW'(RP_CYC + BL2) : TW'(RP_CYC)),
         .busy(rp_busy[b]));
   end

   spacing_timer #(.W(TW)) u_mrd (
      .clk(mem_clk), .rst_n(rst_n), .load(iss_cmd == CMD_MODE),
      .cycles(TW'(MODE_PROGRAM_CYCLE)), .busy(mrd_busy));
   spacing_timer #(.W(TW)) u_rfc (
      .clk(mem_clk), .rst_n(rst_n), .load(iss_cmd == CMD_REF),
      .cycles(TW'(RFC_CYC)), .busy(rfc_busy));
   spacing_timer #(.W(TW)) u_rrd (
      .clk(mem_clk), .rst_n(rst_n), .load(iss_cmd == CMD_ACT),
      .cycles(TW'(RRD_CYC)), .busy(rrd_busy));
   spacing_timer #(.W(TW)) u_wtr (
      .clk(mem_clk), .rst_n(rst_n), .load(iss_cmd == CMD_WR),
      .cycles(TW'(WDATA_CYC + WRITE_TO_READ_GAP)), .busy(wtr_busy));
   spacing_timer #(.W(TW)) u_wpd (
      .clk(mem_clk), .rst_n(rst_n), .load(iss_cmd == CMD_WR),
      .cycles(TW'(WDATA_CYC + WR_CYC)), .busy(wpd_busy));
   spacing_timer #(.W(TW)) u_bst (
      .clk(mem_clk), .rst_n(rst_n),
      .load(iss_cmd == CMD_RD || iss_cmd == CMD_WR),
      .cycles(TW'(BL2)), .busy(bst_busy));

   // Legality of the held request
   always_comb begin
      ras_ok_all = &(~open_q | ~ras_busy);
      case (hold_cmd_q)
         CMD_NOP:  legal = 1'b1;
         CMD_ACT:  legal = !open_q[hold_bank_q] && !rc_busy[hold_bank_q] &&
                           !rp_busy[hold_bank_q] && !rrd_busy && !rfc_busy;
         CMD_RD:   legal = open_q[hold_bank_q] && !rcd_busy[hold_bank_q] &&
                           !wtr_busy && !bst_busy;
         CMD_WR:   legal = open_q[hold_bank_q] && !rcd_busy[hold_bank_q] &&
                           !bst_busy;
         CMD_PRE:  legal = !wpd_busy && (hold_scope_q ? ras_ok_all :
                           !(open_q[hold_bank_q] && ras_busy[hold_bank_q]));
         CMD_REF:  legal = !(|open_q) && !(|rp_busy) && !(|rc_busy) &&
                           !rfc_busy;
         CMD_MODE: legal = !(|open_q) && !(|rp_busy) && !rfc_busy;
         default:  legal = 1'b0;
      endcase
   end

   always_comb begin
      due_bank = '0;
      for (int i = BANKS - 1; i >= 0; i--) begin
         if (due[i]) begin
            due_bank = BANK_W'(i);
         end
      end
   end

   // Upkeep first, then the user request, only when every spacing is met
   always_comb begin
      iss_cmd   = CMD_NOP;
      iss_bank  = '0;
      iss_a10   = 1'b0;
      take_user = 1'b0;
      if (!mrd_busy) begin
         if (ref_pend_q) begin
            if (|open_q) begin
               if (ras_ok_all && !wpd_busy) begin
                  iss_cmd = CMD_PRE;
                  iss_a10 = 1'b1;
               end
            end else if (!(|rp_busy) && !(|rc_busy) && !rfc_busy) begin
               iss_cmd = CMD_REF;
            end
         end else if (|due) begin
            if (!wpd_busy) begin
               iss_cmd  = CMD_PRE;
               iss_bank = due_bank;
            end
         end else if (pend_q && legal) begin
            iss_cmd   = hold_cmd_q;
            iss_bank  = hold_bank_q;
            iss_a10   = hold_scope_q;
            take_user = 1'b1;
         end
      end
   end

   // Registered command pins
   always_ff @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         {cs_n, ras_n, cas_n, we_n} <= PINS_NOP;
         ba   <= '0;
         addr <= '0;
         cke  <= 1'b0;
      end else begin
         cke <= 1'b1;
         ba  <= iss_bank;
         case (iss_cmd)
            CMD_ACT:  {cs_n, ras_n, cas_n, we_n} <= PINS_ACT;
            CMD_RD:   {cs_n, ras_n, cas_n, we_n} <= PINS_RD;
            CMD_WR:   {cs_n, ras_n, cas_n, we_n} <= PINS_WR;
            CMD_PRE:  {cs_n, ras_n, cas_n, we_n} <= PINS_PRE;
            CMD_REF:  {cs_n, ras_n, cas_n, we_n} <= PINS_REF;
            CMD_MODE: {cs_n, ras_n, cas_n, we_n} <= PINS_MODE;
            default:  {cs_n, ras_n, cas_n, we_n} <= PINS_NOP;
         endcase
         if (take_user) begin
            addr <= hold_addr_q;
         end else begin
            addr <= '0;
         end
         if (iss_cmd == CMD_RD || iss_cmd == CMD_WR || iss_cmd == CMD_PRE)
         begin
            addr[PRECHARGE_SCOPE_POS] <= iss_a10;
         end
      end
   end

   // Read capture window and write strobe timing
   always_ff @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_sh_q    <= '0;
         wr_sh_q    <= '0;
         capture_en <= 1'b0;
         dqs_o      <= 1'b0;
         dqs_oe_n   <= 1'b1;
      end else begin
         rd_sh_q    <= {rd_sh_q[SH_LEN-2:0], iss_cmd == CMD_RD};
         wr_sh_q    <= {wr_sh_q[SH_LEN-2:0], iss_cmd == CMD_WR};
         capture_en <= |rd_sh_q[MOD_LAT-1 +: BL2];
         dqs_o      <= |wr_sh_q[WRITE_CMD_TO_FIRST_STROBE-1 +: BL2];
         dqs_oe_n   <= !((iss_cmd == CMD_WR) |
                         (|wr_sh_q[0 +: BL2 + 1]));
      end
   end

endmodule

// ---- ddr_sched_properties.sv ----
module ddr_sched_properties
   import ddr_timing_pkg::*;
#(
   parameter int READ_LATENCY = 2
) (
   input wire logic              mem_clk,
   input wire logic              rst_n,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              dqs_o,
   input wire logic              dqs_oe_n,
   input wire logic              capture_en
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CAP = READ_LATENCY + 1;
   logic [3:0] pins;
   logic       act, rd, wr, pre, rfr, mode;
   logic [7:0] age_q [BANKS];
   assign pins = {cs_n, ras_n, cas_n, we_n};
   assign act  = pins == PINS_ACT;
   assign rd   = pins == PINS_RD;
   assign wr   = pins == PINS_WR;
   assign pre  = pins == PINS_PRE;
   assign rfr  = pins == PINS_REF;
   assign mode = pins == PINS_MODE;
   // Cycles since each bank opened
   always_ff @(posedge mem_clk or negedge rst_n) begin
      for (int i = 0; i < BANKS; i++) begin
         if (!rst_n) begin
            age_q[i] <= 8'hFF;
         end else if (act && int'(ba) == i) begin
            age_q[i] <= 8'h01;
         end else if (age_q[i] != 8'hFF) begin
            age_q[i] <= age_q[i] + 8'h01;
         end
      end
   end
   default clocking cb @(posedge mem_clk); endclocking
   default disable iff (!rst_n);
   a_mode_quiet: assert property (mode |=> pins == PINS_NOP)
      else $error("command right after mode program");
   a_same_bank: assert property (act |-> age_q[ba] >= 8'h06)
      else $error("same bank activates too close");
   a_access_delay: assert property ((rd || wr) |->
      age_q[ba] >= 8'h02)
      else $error("access too soon after activate");
   a_close_min: assert property (pre && !addr[10] |-> age_q[ba] >= 8'h04)
      else $error("bank closed too early");
   a_cross_bank: assert property (act |-> !$past(act))
      else $error("activates to two banks too close");
   a_refresh_gap: assert property (rfr |=> !(act || rfr) [*6])
      else $error("command too soon after refresh");
   a_reopen_gap: assert property (act |-> !($past(pre) &&
      ($past(addr[PRECHARGE_SCOPE_POS]) || $past(ba) == ba)))
      else $error("activate too soon after close");
   a_write_read: assert property (wr |=> !rd [*3])
      else $error("read too soon after write");
   a_strobe_win: assert property (wr |-> !dqs_oe_n && !dqs_o ##1
      (dqs_o && !dqs_oe_n) [*2] ##1 !dqs_oe_n)
      else $error("write strobe out of place");
   a_capture_lat: assert property (rd |-> ##CAP capture_en [*2])
      else $error("read capture window misplaced");
endmodule

// ---- ddr_dimm_model.sv ----
module ddr_dimm_model
   import ddr_timing_pkg::*;
#(
   parameter int CK_PS   = 12000,
   parameter int BL      = 4,
   parameter int RAS_MAX = 200
) (
   input  wire logic              mem_clk,
   input  wire logic              rst_n,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [BANK_W-1:0] ba,
   input  wire logic [ADDR_W-1:0] addr,
   output int                     viol_cnt,
   output int                     ref_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   function automatic int cy(input int ps);
      return (ps + CK_PS - 1) / CK_PS;
   endfunction
   localparam int RAS = cy(45000);
   localparam int RC  = cy(65000);
   localparam int RFC = cy(75000);
   localparam int RCD = cy(20000);
   localparam int RP  = cy(20000);
   localparam int RRD = cy(15000);
   localparam int WR  = cy(15000);
   int         cyc, t_ref, t_mode, t_wr, t_act, b;
   int         t_open [BANKS];
   int         t_shut [BANKS];
   int         t_dal [BANKS];
   bit         open_q [BANKS];
   logic [3:0] pins;
   assign pins = {cs_n, ras_n, cas_n, we_n};
   task automatic flag(input bit bad);
      if (bad) viol_cnt++;
   endtask
   always @(posedge mem_clk or negedge rst_n) begin
      if (!rst_n) begin
         {cyc, viol_cnt, ref_cnt} = 96'h0;
         {t_ref, t_mode, t_wr, t_act} = {4{-32'sh3E8}};
         foreach (open_q[i]) begin
            {t_open[i], t_shut[i], t_dal[i]} = {3{-32'sh3E8}};
            open_q[i] = 1'b0;
         end
      end else begin
         cyc++;
         b = int'(ba);
         if (pins != PINS_NOP) flag(cyc - t_mode < 2);
         foreach (open_q[i])
            flag(open_q[i] && cyc - t_open[i] > RAS_MAX);
         case (pins)
            PINS_MODE: t_mode = cyc;
            PINS_ACT: begin
               flag(open_q[b] || cyc - t_open[b] < RC);
               flag(cyc - t_shut[b] < RP || cyc < t_dal[b]);
               flag(cyc - t_act < RRD || cyc - t_ref < RFC);
               open_q[b] = 1'b1;
               t_open[b] = cyc;
               t_act = cyc;
            end
            PINS_RD, PINS_WR: begin
               flag(!open_q[b] || cyc - t_open[b] < RCD);
               if (pins == PINS_RD) flag(cyc - t_wr < BL / 2 + 2);
               if (pins == PINS_WR) t_wr = cyc;
               if (addr[PRECHARGE_SCOPE_POS]) begin
                  open_q[b] = 1'b0;
                  t_shut[b] = cyc + BL / 2;
                  if (pins == PINS_WR)
                     t_dal[b] = cyc + BL / 2 + 1 + WR + RP;
               end
            end
            PINS_PRE: foreach (open_q[i])
               if (addr[PRECHARGE_SCOPE_POS] || i == b) begin
               flag(open_q[i] && cyc - t_open[i] < RAS);
               open_q[i] = 1'b0;
               t_shut[i] = cyc;
            end
            PINS_REF: begin
               flag(cyc - t_ref < RFC || cyc - t_act < RC);
               foreach (open_q[i]) flag(open_q[i]);
               t_ref = cyc;
               ref_cnt++;
            end
            default: ;
         endcase
      end
   end
endmodule

// ---- ddr_cmd_scheduler_tb.sv ----
module ddr_cmd_scheduler_tb import ddr_timing_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst_n, mem_clk, req_valid, req_scope, req_ready;
   cmd_t              req_cmd;
   logic [BANK_W-1:0] req_bank, ba;
   logic [ADDR_W-1:0] req_addr, addr;
   logic              cke, cs_n, ras_n, cas_n, we_n, dqs_o, dqs_oe_n;
   logic              capture_en;
   int                viol_cnt, ref_cnt, error_cnt, n_compared, cycles;
   int                cap_cnt, stb_cnt;
   ddr_cmd_scheduler #(
      .CK_PERIOD_PS(12000),
      .BURST_LEN(4), .READ_LATENCY(2), .RAS_MAX_CYC(200)
   ) dut_u (
      .clk(clk), .rst_n(rst_n), .mem_clk(mem_clk), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
      .req_scope(req_scope), .req_ready(req_ready), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .capture_en(capture_en)
   );
   ddr_dimm_model model_u (
      .mem_clk(mem_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .viol_cnt(viol_cnt), .ref_cnt(ref_cnt)
   );
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      mem_clk = 1'b0;
      #7;
      forever #24 mem_clk = ~mem_clk;
   end
   // Burst cycles seen on the capture and strobe outputs
   always @(posedge mem_clk) begin
      cap_cnt <= cap_cnt + int'(capture_en);
      stb_cnt <= stb_cnt + int'(dqs_o);
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge clk);
      check(req_ready, 1'b1, "request ready");
   endtask
   task automatic send(cmd_t c, logic [1:0] bk, logic [12:0] a, logic sc);
      wait_ready();
      {req_valid, req_cmd, req_bank} = {1'b1, c, bk};
      {req_addr, req_scope} = {a, sc};
      @(negedge clk);
      req_valid = 1'b0;
      @(negedge clk);
      wait_ready();
   endtask
   task automatic t_mode();
      @(negedge clk);
      check(cke, 1'b1, "cke");
      send(CMD_MODE, 2'h0, 13'h0022, 1'b0);
      send(CMD_ACT, 2'h0, 13'h0100, 1'b0);
      check(viol_cnt, 0, "mode spacing");
      $display("test mode done");
   endtask
   task automatic t_access();
      send(CMD_WR, 2'h0, 13'h0010, 1'b0);
      send(CMD_RD, 2'h0, 13'h0010, 1'b0);
      send(CMD_WR, 2'h0, 13'h0020, 1'b1);
      send(CMD_ACT, 2'h0, 13'h0200, 1'b0);
      send(CMD_RD, 2'h0, 13'h0020, 1'b1);
      check(viol_cnt, 0, "access spacing");
      repeat (2) @(negedge clk);
      check(cap_cnt, 4, "capture cycles");
      check(stb_cnt, 4, "strobe cycles");
      $display("test access done");
   endtask
   task automatic t_banks();
      send(CMD_ACT, 2'h1, 13'h0001, 1'b0);
      send(CMD_ACT, 2'h2, 13'h0002, 1'b0);
      send(CMD_PRE, 2'h1, 13'h0000, 1'b0);
      send(CMD_ACT, 2'h1, 13'h0003, 1'b0);
      send(CMD_PRE, 2'h0, 13'h0000, 1'b1);
      send(CMD_ACT, 2'h2, 13'h0004, 1'b0);
      check(viol_cnt, 0, "bank spacing");
      $display("test banks done");
   endtask
   task automatic t_refresh();
      int refs;
      send(CMD_PRE, 2'h0, 13'h0000, 1'b1);
      send(CMD_REF, 2'h0, 13'h0000, 1'b0);
      send(CMD_ACT, 2'h3, 13'h0005, 1'b0);
      refs = ref_cnt;
      repeat (800) @(negedge clk);
      check(ref_cnt - refs >= 2, 1'b1, "refresh count");
      check(viol_cnt, 0, "refresh and open limit");
      $display("test refresh done");
   endtask
   initial begin
      {rst_n, req_valid, req_scope, req_bank, req_addr} = '0;
      req_cmd = CMD_NOP;
      {error_cnt, n_compared, cycles} = 96'h0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_mode();
      t_access();
      t_banks();
      t_refresh();
      conclude();
   end
endmodule
bind ddr_cmd_scheduler ddr_sched_properties #(
   .READ_LATENCY(READ_LATENCY)
) props_u (
   .mem_clk(mem_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqs_o(dqs_o),
   .dqs_oe_n(dqs_oe_n), .capture_en(capture_en)
);
